/* shared/gpp_pkg.sv */
// Constants shared by the general pin port: register map, field positions,
// reset values and timing figures.
// Assumes a byte-addressed configuration bus with 32-bit data words.
package gpp_pkg;

  localparam int unsigned GPP_PINS = 16;

  // Register byte addresses on the configuration bus
  localparam logic [31:0] GPP_ADDR_ENABLE = 32'h01B0_0000;
  localparam logic [31:0] GPP_ADDR_DIRECTION = 32'h01B0_0004;
  localparam logic [31:0] GPP_ADDR_VALUE = 32'h01B0_0008;
  localparam logic [31:0] GPP_ADDR_RISE_FLAGS = 32'h01B0_0010;
  localparam logic [31:0] GPP_ADDR_RISE_MASK = 32'h01B0_0014;
  localparam logic [31:0] GPP_ADDR_FALL_FLAGS = 32'h01B0_0018;
  localparam logic [31:0] GPP_ADDR_FALL_MASK = 32'h01B0_001C;
  localparam logic [31:0] GPP_ADDR_GLOBAL_CTRL = 32'h01B0_0020;
  localparam logic [31:0] GPP_ADDR_POLARITY = 32'h01B0_0024;

  // Reset values
  localparam logic [15:0] GPP_RST_ENABLE = 16'h00FF;
  localparam logic [15:0] GPP_RST_DIRECTION = 16'h0000;
  localparam logic [15:0] GPP_RST_VALUE = 16'h0000;
  localparam logic [15:0] GPP_RST_MASK = 16'h0000;
  localparam logic [15:0] GPP_RST_POLARITY = 16'h0000;
  localparam logic [2:0] GPP_RST_GLOBAL = 3'h0;

  // Global control field positions
  localparam int unsigned GPP_GC_DELTA_BIT = 0;
  localparam int unsigned GPP_GC_AND_BIT = 1;
  localparam int unsigned GPP_GC_INVERT_BIT = 2;
  localparam int unsigned GPP_GC_WIDTH = 3;

  // Input synchroniser depth
  localparam int unsigned GPP_SYNC_STAGES = 2;

  // Clock and the least input hold time for software polling
  localparam int unsigned GPP_CLK_PERIOD_PS = 5000;
  localparam int unsigned GPP_POLL_HOLD_PERIODS = 12;
  localparam int unsigned GPP_POLL_HOLD_PS = GPP_POLL_HOLD_PERIODS * GPP_CLK_PERIOD_PS;
  localparam int unsigned GPP_POLL_HOLD_CYCLES = (GPP_POLL_HOLD_PS + GPP_CLK_PERIOD_PS - 1) / GPP_CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    GPP_EVT_IDLE,
    GPP_EVT_ACTIVE
  } gpp_evt_state_type;

endpackage

/* shared/gpp_sync_if.sv */
// Carrier for the synchronised pin levels and their edges.
// Assumes producer and consumer share clock_i.
`timescale 1ns/10ps
interface gpp_sync_if #(
  parameter int unsigned WIDTH = 16
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

/* src/gpp_pin_sync.sv */
// Two-flop synchroniser and edge detector for the general pins.
// Assumes pin inputs are asynchronous to clock_i.
`timescale 1ns/10ps
module gpp_pin_sync
  import gpp_pkg::*;
#(
  parameter int unsigned WIDTH = GPP_PINS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Raw pins
  input wire logic [WIDTH-1:0] pin_i,
  // Synchronised view
  gpp_sync_if.src sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] prev_r;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      stable_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      stable_r <= meta_r;
      prev_r <= stable_r;
    end
  end

  assign sync_o.level = stable_r;
  assign sync_o.rise = stable_r & ~prev_r;
  assign sync_o.fall = ~stable_r & prev_r;

endmodule

/* src/gpp_event_gen.sv */
// Combines per-pin change flags or levels into one event condition.
// Assumes all inputs are registers on clock_i; output is combinational.
`timescale 1ns/10ps
module gpp_event_gen
  import gpp_pkg::*;
#(
  parameter int unsigned WIDTH = GPP_PINS
) (
  // Per-pin sources
  input wire logic [WIDTH-1:0] level_i,
  input wire logic [WIDTH-1:0] input_pins_i,
  input wire logic [WIDTH-1:0] rise_flags_i,
  input wire logic [WIDTH-1:0] fall_flags_i,
  // Settings
  input wire logic [WIDTH-1:0] rise_mask_i,
  input wire logic [WIDTH-1:0] fall_mask_i,
  input wire logic [WIDTH-1:0] polarity_i,
  input wire logic [GPP_GC_WIDTH-1:0] global_i,
  // Result
  output logic event_o
);

  wire [WIDTH-1:0] selected = (rise_mask_i | fall_mask_i) & input_pins_i;
  wire [WIDTH-1:0] delta_term = (rise_flags_i & rise_mask_i) | (fall_flags_i & fall_mask_i);
  // Polarity one means the pin is active low
  wire [WIDTH-1:0] pass_term = level_i ^ polarity_i;
  wire [WIDTH-1:0] term = global_i[GPP_GC_DELTA_BIT] ? delta_term : pass_term;
  wire any_hit = |(term & selected);
  // An empty selection never satisfies the AND mode
  wire all_hit = (|selected) & (&(term | ~selected));
  wire raw = global_i[GPP_GC_AND_BIT] ? all_hit : any_hit;

  assign event_o = raw ^ global_i[GPP_GC_INVERT_BIT];

endmodule

/* src/gpp_top.sv */
// General pin port: sixteen general pins behind a configuration-bus
// register bank, with change flags feeding interrupt and DMA events.
// Assumes a single-cycle configuration bus master on clock_i; pins are
// asynchronous and resolved outside from the output enables.
//
// Behaviour
// - Sixteen pins, 15 down to 0, each with its own enable and direction bit.
// - A pin is under general control only while its enable bit is one.
// - Direction zero makes the pin an input that is never driven.
// - Direction one makes the pin an output driven from the value register.
// - The direction bit of a disabled pin has no effect.
// - Writing the value register sets the level of every enabled output pin.
// - Reading the value register returns the sampled level of enabled input pins.
// - After reset every direction bit selects input.
// - Pin activity raises processor interrupts and DMA events in selectable modes.
// - After reset pins 7 to 0 are enabled and are inputs.
`timescale 1ns/10ps
module gpp_top
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration bus
  input wire logic [31:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  // General pins
  input wire logic [PINS-1:0] general_pins_i,
  output logic [PINS-1:0] general_pins_o,
  output logic [PINS-1:0] general_pins_oe_o,
  // Events
  output logic interrupt_o,
  output logic dma_sync_event_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [PINS-1:0] pin_enable_register_r;
  logic [PINS-1:0] pin_enable_register_nxt;
  logic [PINS-1:0] pin_direction_register_r;
  logic [PINS-1:0] pin_direction_register_nxt;
  logic [PINS-1:0] pin_value_register_r;
  logic [PINS-1:0] pin_value_register_nxt;
  logic [PINS-1:0] rising_change_flags_r;
  logic [PINS-1:0] rising_change_flags_nxt;
  logic [PINS-1:0] falling_change_flags_r;
  logic [PINS-1:0] falling_change_flags_nxt;
  logic [PINS-1:0] rising_change_mask_r;
  logic [PINS-1:0] rising_change_mask_nxt;
  logic [PINS-1:0] falling_change_mask_r;
  logic [PINS-1:0] falling_change_mask_nxt;
  logic [GPP_GC_WIDTH-1:0] port_global_control_r;
  logic [GPP_GC_WIDTH-1:0] port_global_control_nxt;
  logic [PINS-1:0] event_polarity_r;
  logic [PINS-1:0] event_polarity_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  gpp_sync_if #(.WIDTH(PINS)) pin_sync ();

  // Levels shorter than the polling hold may be missed by reads but
  // still latch a change flag once past the synchroniser.
  gpp_pin_sync #(.WIDTH(PINS)) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(general_pins_i),
    .sync_o(pin_sync.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles

  wire [PINS-1:0] output_pins = pin_enable_register_r & pin_direction_register_r;
  wire [PINS-1:0] input_pins = pin_enable_register_r & ~pin_direction_register_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire hit_enable = cfg_addr_i == GPP_ADDR_ENABLE;
  wire hit_direction = cfg_addr_i == GPP_ADDR_DIRECTION;
  wire hit_value = cfg_addr_i == GPP_ADDR_VALUE;
  wire hit_rise_flags = cfg_addr_i == GPP_ADDR_RISE_FLAGS;
  wire hit_rise_mask = cfg_addr_i == GPP_ADDR_RISE_MASK;
  wire hit_fall_flags = cfg_addr_i == GPP_ADDR_FALL_FLAGS;
  wire hit_fall_mask = cfg_addr_i == GPP_ADDR_FALL_MASK;
  wire hit_global = cfg_addr_i == GPP_ADDR_GLOBAL_CTRL;
  wire hit_polarity = cfg_addr_i == GPP_ADDR_POLARITY;

  wire wr_enable = cfg_wr_i & hit_enable;
  wire wr_direction = cfg_wr_i & hit_direction;
  wire wr_value = cfg_wr_i & hit_value;
  wire wr_rise_flags = cfg_wr_i & hit_rise_flags;
  wire wr_rise_mask = cfg_wr_i & hit_rise_mask;
  wire wr_fall_flags = cfg_wr_i & hit_fall_flags;
  wire wr_fall_mask = cfg_wr_i & hit_fall_mask;
  wire wr_global = cfg_wr_i & hit_global;
  wire wr_polarity = cfg_wr_i & hit_polarity;

  wire [PINS-1:0] wdata_pins = cfg_wdata_i[PINS-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state of plain registers

  assign pin_enable_register_nxt = wr_enable ? wdata_pins : pin_enable_register_r;
  assign pin_direction_register_nxt = wr_direction ? wdata_pins : pin_direction_register_r;
  // Bits of input pins are stored too and drive once the pin turns output
  assign pin_value_register_nxt = wr_value ? wdata_pins : pin_value_register_r;
  assign rising_change_mask_nxt = wr_rise_mask ? wdata_pins : rising_change_mask_r;
  assign falling_change_mask_nxt = wr_fall_mask ? wdata_pins : falling_change_mask_r;
  assign port_global_control_nxt = wr_global ? cfg_wdata_i[GPP_GC_WIDTH-1:0] : port_global_control_r;
  assign event_polarity_nxt = wr_polarity ? wdata_pins : event_polarity_r;

  // Drive roles after this edge, so level and enable change together
  wire [PINS-1:0] output_pins_nxt = pin_enable_register_nxt & pin_direction_register_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Change flags: one per pin, write one to clear, a new edge wins

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_flag
      wire rise_set = pin_sync.rise[gi] & input_pins[gi];
      wire fall_set = pin_sync.fall[gi] & input_pins[gi];
      wire rise_clr = wr_rise_flags & cfg_wdata_i[gi];
      wire fall_clr = wr_fall_flags & cfg_wdata_i[gi];
      assign rising_change_flags_nxt[gi] = rise_set | (rising_change_flags_r[gi] & ~rise_clr);
      assign falling_change_flags_nxt[gi] = fall_set | (falling_change_flags_r[gi] & ~fall_clr);
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_enable_register_r <= GPP_RST_ENABLE;
      pin_direction_register_r <= GPP_RST_DIRECTION;
      pin_value_register_r <= GPP_RST_VALUE;
      rising_change_flags_r <= '0;
      falling_change_flags_r <= '0;
      rising_change_mask_r <= GPP_RST_MASK;
      falling_change_mask_r <= GPP_RST_MASK;
      port_global_control_r <= GPP_RST_GLOBAL;
      event_polarity_r <= GPP_RST_POLARITY;
    end else begin
      pin_enable_register_r <= pin_enable_register_nxt;
      pin_direction_register_r <= pin_direction_register_nxt;
      pin_value_register_r <= pin_value_register_nxt;
      rising_change_flags_r <= rising_change_flags_nxt;
      falling_change_flags_r <= falling_change_flags_nxt;
      rising_change_mask_r <= rising_change_mask_nxt;
      falling_change_mask_r <= falling_change_mask_nxt;
      port_global_control_r <= port_global_control_nxt;
      event_polarity_r <= event_polarity_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so pins never glitch on decode

  logic [PINS-1:0] pins_out_r;
  logic [PINS-1:0] pins_oe_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_out_r <= '0;
      pins_oe_r <= '0;
    end else begin
      pins_out_r <= pin_value_register_nxt & output_pins_nxt;
      pins_oe_r <= output_pins_nxt;
    end
  end

  assign general_pins_o = pins_out_r;
  assign general_pins_oe_o = pins_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Inputs show the pin, outputs show what is driven, disabled pins read zero
  wire [PINS-1:0] value_view = (pin_sync.level & input_pins) | (pin_value_register_r & output_pins);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (1'b1)
      hit_enable: rd_mux[PINS-1:0] = pin_enable_register_r;
      hit_direction: rd_mux[PINS-1:0] = pin_direction_register_r;
      hit_value: rd_mux[PINS-1:0] = value_view;
      hit_rise_flags: rd_mux[PINS-1:0] = rising_change_flags_r;
      hit_rise_mask: rd_mux[PINS-1:0] = rising_change_mask_r;
      hit_fall_flags: rd_mux[PINS-1:0] = falling_change_flags_r;
      hit_fall_mask: rd_mux[PINS-1:0] = falling_change_mask_r;
      hit_global: rd_mux[GPP_GC_WIDTH-1:0] = port_global_control_r;
      hit_polarity: rd_mux[PINS-1:0] = event_polarity_r;
      default: rd_mux = '0;
    endcase
  end

  logic [31:0] rdata_r;
  logic ack_r;

  // Every access is answered, unmapped ones with zero data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
      ack_r <= 1'b0;
    end else begin
      rdata_r <= cfg_rd_i ? rd_mux : '0;
      ack_r <= cfg_rd_i | cfg_wr_i;
    end
  end

  assign cfg_rdata_o = rdata_r;
  assign cfg_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Event generation

  wire event_cond;

  gpp_event_gen #(.WIDTH(PINS)) u_event (
    .level_i(pin_sync.level),
    .input_pins_i(input_pins),
    .rise_flags_i(rising_change_flags_r),
    .fall_flags_i(falling_change_flags_r),
    .rise_mask_i(rising_change_mask_r),
    .fall_mask_i(falling_change_mask_r),
    .polarity_i(event_polarity_r),
    .global_i(port_global_control_r),
    .event_o(event_cond)
  );

  gpp_evt_state_type evt_state_r;
  gpp_evt_state_type evt_state_nxt;
  logic irq_r;
  logic dma_r;

  // One pulse per assertion: a held condition must drop before it fires again
  always_comb begin
    evt_state_nxt = evt_state_r;
    case (evt_state_r)
      GPP_EVT_IDLE: begin
        if (event_cond) begin
          evt_state_nxt = GPP_EVT_ACTIVE;
        end
      end
      GPP_EVT_ACTIVE: begin
        if (!event_cond) begin
          evt_state_nxt = GPP_EVT_IDLE;
        end
      end
      default: evt_state_nxt = GPP_EVT_IDLE;
    endcase
  end

  wire evt_fire = (evt_state_r == GPP_EVT_IDLE) & event_cond;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_state_r <= GPP_EVT_IDLE;
      irq_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      evt_state_r <= evt_state_nxt;
      irq_r <= evt_fire;
      dma_r <= evt_fire;
    end
  end

  assign interrupt_o = irq_r;
  assign dma_sync_event_o = dma_r;

endmodule

/* bench/gpp_top_assertions.sv */
// Concurrent checks on the general pin port top ports.
// Assumes one clock domain and bind from the bench top file.
`timescale 1ns/10ps
module gpp_top_assertions
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Configuration bus
  input wire logic [31:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_ack_o,
  // Pins and events
  input wire logic [PINS-1:0] general_pins_i,
  input wire logic [PINS-1:0] general_pins_o,
  input wire logic [PINS-1:0] general_pins_oe_o,
  input wire logic interrupt_o,
  input wire logic dma_sync_event_o
);
  logic [PINS-1:0] wdata_r;

  // Write data of the previous edge, for drive checks
  always_ff @(posedge clock_i) begin
    wdata_r <= cfg_wdata_i[PINS-1:0];
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////
  ack_on_access_a: assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("no answer one cycle after an access");
  ack_only_a: assert property (!(cfg_wr_i || cfg_rd_i) |=> !cfg_ack_o)
    else $error("answer without an access");
  rdata_idle_a: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("read data not zero outside an answer");
  upper_zero_a: assert property (cfg_ack_o |-> cfg_rdata_o[31:16] == 16'h0)
    else $error("read data above the sixteen pins not zero");
  enable_off_a: assert property ((cfg_wr_i && cfg_addr_i == GPP_ADDR_ENABLE &&
    cfg_wdata_i[PINS-1:0] == '0) |=> general_pins_oe_o == '0)
    else $error("disabled pin still driven");
  dir_input_a: assert property ((cfg_wr_i && cfg_addr_i == GPP_ADDR_DIRECTION &&
    cfg_wdata_i[PINS-1:0] == '0) |=> general_pins_oe_o == '0)
    else $error("input pin still driven");
  value_drive_a: assert property ((cfg_wr_i && cfg_addr_i == GPP_ADDR_VALUE)
    |=> ((general_pins_o ^ wdata_r) & general_pins_oe_o) == '0)
    else $error("output pin level differs from written value");
  oe_reset_a: assert property ($rose(rst_n_i) |-> general_pins_oe_o == '0)
    else $error("pin driven right after reset");
  event_twin_a: assert property (interrupt_o == dma_sync_event_o)
    else $error("interrupt and dma event differ");
  pulse_single_a: assert property (interrupt_o |=> !interrupt_o)
    else $error("interrupt longer than one cycle");

  cover property (cfg_wr_i && cfg_addr_i == GPP_ADDR_DIRECTION);
  cover property (cfg_rd_i && cfg_addr_i == GPP_ADDR_VALUE);
  cover property (interrupt_o);
endmodule

/* bench/gpp_pin_model.sv */
// Far-side devices wired to the general pins.
// Assumes the bench commands each level and holds it for the polling time.
`timescale 1ns/10ps
module gpp_pin_model
  import gpp_pkg::*;
#(
  parameter int unsigned PINS = GPP_PINS
) (
  // Far-side levels
  input wire logic [PINS-1:0] level_i,
  // Port drive
  input wire logic [PINS-1:0] drive_i,
  input wire logic [PINS-1:0] drive_oe_i,
  // Resolved wire
  output logic [PINS-1:0] pins_o
);
  // Far side yields wherever the port drives
  assign pins_o = (drive_oe_i & drive_i) | (~drive_oe_i & level_i);
endmodule

/* bench/test_gpp_top.sv */
// Self-checking bench for the general pin port.
// Assumes gpp_top, the pin model and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_gpp_top;
  import gpp_pkg::*;
  logic clock_i, rst_n_i, cfg_wr_i, cfg_rd_i, cfg_ack_o, interrupt_o, dma_sync_event_o;
  logic [31:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
  logic [15:0] ext_level, pin_wire, general_pins_o, general_pins_oe_o;
  int err_count = 0;
  int total_checks = 0;
  int irq_n = 0;
  int dma_n = 0;
  logic [31:0] zr [8] = '{GPP_ADDR_VALUE, 32'h01B0_000C, GPP_ADDR_RISE_FLAGS, GPP_ADDR_RISE_MASK,
    GPP_ADDR_FALL_FLAGS, GPP_ADDR_FALL_MASK, GPP_ADDR_GLOBAL_CTRL, GPP_ADDR_POLARITY};

  gpp_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
    .general_pins_i(pin_wire), .general_pins_o(general_pins_o), .general_pins_oe_o(general_pins_oe_o),
    .interrupt_o(interrupt_o), .dma_sync_event_o(dma_sync_event_o));
  gpp_pin_model far (.level_i(ext_level), .drive_i(general_pins_o), .drive_oe_i(general_pins_oe_o),
    .pins_o(pin_wire));

  ////////////////////////////////////////////////////////////
  initial begin
    clock_i = 0;
    forever #2.5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (interrupt_o !== 1'b0) irq_n <= irq_n + 1;
    if (dma_sync_event_o !== 1'b0) dma_n <= dma_n + 1;
  end

  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge clock_i);
    cfg_wr_i = wr;
    cfg_rd_i = !wr;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(negedge clock_i);
    cfg_wr_i = 0;
    cfg_rd_i = 0;
    `CHK(cfg_ack_o, 1'b1)
    if (!wr) `CHK(cfg_rdata_o, d)
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    acc(1'b0, a, e);
  endtask

  // Far side holds every level for the polling time
  task automatic settle(input logic [15:0] v);
    ext_level = v;
    repeat (GPP_POLL_HOLD_CYCLES) @(negedge clock_i);
  endtask

  task automatic ev(input int n);
    `CHK(irq_n, n)
    `CHK(dma_n, n)
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    report_and_stop;
  end

  initial begin
    rst_n_i = 0;
    cfg_wr_i = 0;
    cfg_rd_i = 0;
    cfg_addr_i = 32'h0;
    cfg_wdata_i = 32'h0;
    ext_level = 16'h0000;
    repeat (6) @(negedge clock_i);
    rst_n_i = 1;
    `CHK(general_pins_oe_o, 16'h0000)
    rd(GPP_ADDR_ENABLE, 32'h0000_00FF);
    rd(GPP_ADDR_DIRECTION, 32'h0);
    foreach (zr[i]) rd(zr[i], 32'h0);
    wr(GPP_ADDR_RISE_MASK, 32'hFFFF_FFFF);
    rd(GPP_ADDR_RISE_MASK, 32'h0000_FFFF);
    wr(GPP_ADDR_GLOBAL_CTRL, 32'hFFFF_FFFB);
    rd(GPP_ADDR_GLOBAL_CTRL, 32'h0000_0003);
    wr(GPP_ADDR_RISE_MASK, 32'h0);
    wr(GPP_ADDR_GLOBAL_CTRL, 32'h0);
    // Drive, disable and direction interplay
    wr(GPP_ADDR_VALUE, 32'h0000_A5C3);
    wr(GPP_ADDR_DIRECTION, 32'h0000_FFFF);
    `CHK(general_pins_oe_o, 16'h00FF)
    `CHK(general_pins_o, 16'h00C3)
    rd(GPP_ADDR_VALUE, 32'h0000_00C3);
    wr(GPP_ADDR_ENABLE, 32'h0000_FF00);
    wr(GPP_ADDR_DIRECTION, 32'h0000_F0F0);
    `CHK(general_pins_oe_o, 16'hF000)
    `CHK(general_pins_o, 16'hA000)
    wr(GPP_ADDR_ENABLE, 32'h0);
    `CHK(general_pins_oe_o, 16'h0000)
    wr(GPP_ADDR_ENABLE, 32'h0000_FFFF);
    wr(GPP_ADDR_DIRECTION, 32'h0000_FF00);
    settle(16'h1234);
    rd(GPP_ADDR_VALUE, 32'h0000_A534);
    wr(GPP_ADDR_VALUE, 32'h0000_5A00);
    `CHK(general_pins_o, 16'h5A00)
    // Delta mode with OR combine
    wr(GPP_ADDR_DIRECTION, 32'h0);
    settle(16'h0000);
    wr(GPP_ADDR_RISE_FLAGS, 32'h0000_FFFF);
    wr(GPP_ADDR_FALL_FLAGS, 32'h0000_FFFF);
    rd(GPP_ADDR_RISE_FLAGS, 32'h0);
    wr(GPP_ADDR_RISE_MASK, 32'h1);
    wr(GPP_ADDR_GLOBAL_CTRL, 32'h1);
    ev(0);
    settle(16'h0001);
    ev(1);
    rd(GPP_ADDR_RISE_FLAGS, 32'h1);
    rd(GPP_ADDR_FALL_FLAGS, 32'h0);
    wr(GPP_ADDR_RISE_FLAGS, 32'h1);
    rd(GPP_ADDR_RISE_FLAGS, 32'h0);
    wr(GPP_ADDR_FALL_MASK, 32'h1);
    settle(16'h0000);
    ev(2);
    rd(GPP_ADDR_FALL_FLAGS, 32'h1);
    // Pass-through mode and polarity
    wr(GPP_ADDR_GLOBAL_CTRL, 32'h0);
    settle(16'h0001);
    ev(3);
    wr(GPP_ADDR_POLARITY, 32'h1);
    ev(3);
    settle(16'h0000);
    ev(4);
    // Delta mode with AND combine over two pins
    wr(GPP_ADDR_POLARITY, 32'h0);
    wr(GPP_ADDR_FALL_MASK, 32'h0);
    wr(GPP_ADDR_RISE_MASK, 32'h3);
    wr(GPP_ADDR_RISE_FLAGS, 32'h0000_FFFF);
    wr(GPP_ADDR_FALL_FLAGS, 32'h0000_FFFF);
    wr(GPP_ADDR_GLOBAL_CTRL, 32'h3);
    settle(16'h0001);
    ev(4);
    settle(16'h0003);
    ev(5);
    // Inverted result fires once the flags are cleared
    wr(GPP_ADDR_GLOBAL_CTRL, 32'h7);
    wr(GPP_ADDR_RISE_FLAGS, 32'h3);
    settle(16'h0003);
    ev(6);
    // Reset in mid-run restores the defaults
    rst_n_i = 0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1;
    `CHK(general_pins_oe_o, 16'h0000)
    rd(GPP_ADDR_ENABLE, 32'h0000_00FF);
    rd(GPP_ADDR_GLOBAL_CTRL, 32'h0);
    settle(16'h0003);
    rd(GPP_ADDR_RISE_FLAGS, 32'h3);
    ev(6);
    report_and_stop;
  end
endmodule

bind gpp_top gpp_top_assertions #(.PINS(PINS)) chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .general_pins_i(general_pins_i),
  .general_pins_o(general_pins_o), .general_pins_oe_o(general_pins_oe_o),
  .interrupt_o(interrupt_o), .dma_sync_event_o(dma_sync_event_o));
